/* File: design/scs_pkg.sv */
// Package of constants and types for the conversion sequencer
package scs_pkg;

    // ========================================
    // Converter geometry and timing
    localparam int RES_BITS = 16;
    localparam int CLK_MHZ = 25;
    localparam int APERTURE_NS = 2;
    localparam int APERTURE_CYCLES =
        ((APERTURE_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
        (APERTURE_NS * CLK_MHZ + 999) / 1000;
    localparam int ACQ_NS = 250;
    localparam int ACQ_CYCLES = (ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_US = 1000;
    localparam int GAP_CYCLES = GAP_US * CLK_MHZ;
    localparam int BIT_DIV = 2;

    // ========================================
    // Register offsets and reset values
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_RESULT = 12'h008;
    localparam logic [11:0] OFS_COUNT = 12'h00c;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam int MODE_LSB = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_STALE = 1;
    localparam int ST_PDOWN = 2;
    localparam int ST_SAVE = 3;
    localparam logic [15:0] CODE_TOP = 16'hffff;
    localparam logic [15:0] CODE_BOTTOM = 16'h0000;
    localparam logic [15:0] CODE_MSB = 16'h8000;

    // ========================================
    // Modes and states
    typedef enum logic [1:0]
    {
        MODE_NORMAL = 2'h0,
        MODE_FAST = 2'h1,
        MODE_LOW_POWER = 2'h2
    } scs_mode_e;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'b00001,
        ST_APERTURE = 5'b00010,
        ST_CONVERT = 5'b00100,
        ST_LATCH = 5'b01000,
        ST_ACQUIRE = 5'b10000
    } scs_state_e;

    // Status fields that travel together to the register read path
    typedef struct packed
    {
        logic save;
        logic pdown;
        logic stale;
        logic busy;
    } scs_status_s;

endpackage

/* File: design/scs_bit_divider.sv */
// Divider that paces the bit search with one-cycle enable pulses
`timescale 1ns/1ps
module scs_bit_divider #(
    parameter int DIV = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic tick
);
    import scs_pkg::*;

    logic [7:0] count;
    logic [7:0] next_count;
    logic wrap;

    // Restart from zero whenever the search is not running
    assign wrap = (count == 8'(DIV - 1));
    assign next_count = (!run || wrap) ? 8'h00 : count + 8'h01;
    assign tick = run && wrap;

    // ========================================
    // Counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= 8'h00;
        else
            count <= next_count;
    end
endmodule

/* File: design/scs_sequencer.sv */
// Successive-approximation conversion sequencer with APB registers
// Overview of operation
// (RULE1) Falling start input begins a conversion
// (RULE2) Hold input fixed aperture after start
// (RULE3) Search bits MSB first, binary weighted
// (RULE4) Form code, then drop busy
// (RULE5) Result belongs to the just-finished conversion
// (RULE6) Host discards fast-mode result after gap
// (RULE7) Normal mode has no gap limit
// (RULE8) Low-power mode saves power between conversions
// (RULE9) Coding select gives binary or twos complement
// (RULE10) Ideal codes for every listed level
// (RULE11) Overrange saturates at top code
// (RULE12) Underrange saturates at bottom code
// (RULE13) Busy high from start until result latched
// (RULE14) Reset input aborts and reinitialises
// (RULE15) Power-down finishes current, refuses new
// (RULE16) Low-power: start already low starts conversion
// (RULE17) Coding select high means binary, sampled late
// (RULE18) Starts while busy are ignored
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module scs_sequencer #(
    parameter int GAP_LIMIT = scs_pkg::GAP_CYCLES,
    parameter int DIV = scs_pkg::BIT_DIV
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic convert_start_n,
    input wire logic coding_select,
    input wire logic power_down_in,
    input wire logic reset_in,
    input wire logic comp_above,
    input wire logic input_ground_sense,
    input wire logic input_above_span,
    output logic sample_hold,
    output logic [15:0] trial_code,
    output logic busy,
    output logic power_save,
    output logic [15:0] result_code,
    output logic result_stale
);
    import scs_pkg::*;

    // ========================================
    // Declarations
    scs_state_e state;
    scs_state_e next_state;
    scs_mode_e mode;
    scs_status_s status;
    logic start_prev;
    logic start_fall;
    logic start_ok;
    logic [15:0] acc;
    logic [15:0] mask;
    logic [7:0] wait_count;
    logic wait_done;
    logic [31:0] gap_count;
    logic gap_long;
    logic stale_pending;
    logic [31:0] conv_count;
    logic tick;
    logic last_bit;
    logic [15:0] next_acc;
    logic [15:0] raw_code;
    logic apb_write;
    logic apb_read;
    logic hit_control;
    logic hit_status;
    logic hit_result;
    logic hit_count;
    logic hit_any;

    // Straight binary passes through, twos complement flips the MSB
    function automatic logic [15:0] format_code(input logic [15:0] code,
                                                input logic binary);
        format_code = binary ? code : (code ^ CODE_MSB);
    endfunction

    // ========================================
    // Start detection
    // The start pin is taken as synchronous, so one register suffices
    assign start_fall = start_prev && !convert_start_n; // [RULE1]
    // Power-down gates new requests here; starts while busy are dropped because only ST_IDLE takes start_ok
    assign start_ok = start_fall && !power_down_in; // [RULE15] [RULE18]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_prev <= 1'b1;
        else
            start_prev <= convert_start_n;
    end

    // ========================================
    // Bit pacing
    scs_bit_divider #(
        .DIV(DIV)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(state == ST_CONVERT),
        .tick(tick)
    );

    // Keep the trial bit if the held input sits at or above it
    assign last_bit = (mask == 16'h0001);
    assign next_acc = (comp_above ? acc : (acc & ~mask))
                      | (mask >> 1); // [RULE3]
    assign wait_done = (wait_count == 8'h00);

    // Saturate outside the span instead of trusting the search
    assign raw_code = input_above_span ? CODE_TOP : // [RULE11]
                      input_ground_sense ? CODE_BOTTOM : // [RULE12]
                      next_acc & ~(mask >> 1) |
                      (comp_above ? mask : 16'h0000); // [RULE10]

    // ========================================
    // Sequencer next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
                if (start_ok)
                    next_state = ST_APERTURE; // [RULE1]
            ST_APERTURE:
                if (wait_done)
                    next_state = ST_CONVERT; // [RULE2]
            ST_CONVERT:
                if (tick && last_bit)
                    next_state = ST_LATCH;
            ST_LATCH:
                if (mode == MODE_LOW_POWER)
                    next_state = ST_ACQUIRE;
                else
                    next_state = ST_IDLE;
            ST_ACQUIRE:
                if (wait_done)
                    // Start already low: convert at once
                    next_state = (!convert_start_n && !power_down_in) ?
                                 ST_APERTURE : ST_IDLE; // [RULE16]
            default:
                next_state = ST_IDLE;
        endcase
    end

    // ========================================
    // Sequencer state and search registers
    // The soft reset input aborts any search in flight
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= ST_IDLE;
        else if (reset_in)
            state <= ST_IDLE; // [RULE14]
        else
            state <= next_state;
    end

    // Wait counter serves both aperture and acquisition intervals
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wait_count <= 8'h00;
        else if (next_state == ST_APERTURE && state != ST_APERTURE)
            wait_count <= 8'(APERTURE_CYCLES - 1); // [RULE2]
        else if (next_state == ST_ACQUIRE && state != ST_ACQUIRE)
            wait_count <= 8'(ACQ_CYCLES - 1);
        else if (!wait_done)
            wait_count <= wait_count - 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc <= CODE_MSB;
            mask <= CODE_MSB;
        end
        else if (state == ST_APERTURE)
        begin
            acc <= CODE_MSB; // [RULE3]
            mask <= CODE_MSB;
        end
        else if (state == ST_CONVERT && tick)
        begin
            acc <= next_acc; // [RULE3]
            mask <= mask >> 1;
        end
    end

    // ========================================
    // Result latch, no pipeline between search and output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_code <= CODE_BOTTOM;
        else if (state == ST_CONVERT && tick && last_bit && !reset_in)
            result_code <= format_code(raw_code, // [RULE5] [RULE9]
                                       coding_select); // [RULE17]
    end

    // ========================================
    // Gap watch for the fast mode
    // The host decides whether to discard; the device only flags it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gap_count <= 32'h0000_0000;
        else if (state == ST_LATCH)
            gap_count <= 32'h0000_0000;
        else if (!gap_long)
            gap_count <= gap_count + 32'h0000_0001;
    end

    // Counter starts at zero after reset, but stale_pending forces gap_long: power-up counts as a gap
    assign gap_long = (gap_count >= 32'(GAP_LIMIT)) || stale_pending;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stale_pending <= 1'b1;
        else if (state == ST_LATCH)
            stale_pending <= 1'b0;
    end

    // Normal and low-power modes never flag a stale result
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_stale <= 1'b0;
        else if (state == ST_IDLE && start_ok)
            result_stale <= gap_long && (mode == MODE_FAST); // [RULE6] [RULE7]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            conv_count <= 32'h0000_0000;
        else if (state == ST_LATCH)
            conv_count <= conv_count + 32'h0000_0001;
    end

    // ========================================
    // Pin outputs
    // Busy covers aperture, search and the latch cycle
    assign busy = (state == ST_APERTURE) || (state == ST_CONVERT)
                  || (state == ST_LATCH); // [RULE13] [RULE4]
    assign sample_hold = (state == ST_CONVERT) || (state == ST_LATCH);
    assign trial_code = acc;
    // Front end sleeps only while idle in low-power mode or powered down
    assign power_save = (state == ST_IDLE) &&
                        ((mode == MODE_LOW_POWER) || power_down_in); // [RULE8]

    assign status.busy = busy;
    assign status.stale = result_stale;
    assign status.pdown = power_down_in;
    assign status.save = power_save;

    // ========================================
    // APB slave, zero wait states
    assign hit_control = (paddr == OFS_CONTROL);
    assign hit_status = (paddr == OFS_STATUS);
    assign hit_result = (paddr == OFS_RESULT);
    assign hit_count = (paddr == OFS_COUNT);
    assign hit_any = hit_control || hit_status || hit_result || hit_count;
    assign apb_write = psel && penable && pwrite;
    assign apb_read = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // Mode changes mid-conversion only steer what follows the latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode <= scs_mode_e'(RST_MODE);
        else if (apb_write && hit_control && pwdata[1:0] != 2'h3)
            mode <= scs_mode_e'(pwdata[MODE_LSB +: 2]);
    end

    // Read data registered in the setup cycle, valid in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (apb_read)
        begin
            if (hit_control)
                prdata <= {30'h0000_0000, mode};
            else if (hit_status)
                prdata <= {28'h000_0000, status};
            else if (hit_result)
                prdata <= {16'h0000, result_code};
            else if (hit_count)
                prdata <= conv_count;
            else
                prdata <= 32'h0000_0000;
        end
    end
endmodule

/* File: sim/scs_sequencer_checker.sv */
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module scs_sequencer_checker #(
    parameter int DIV = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic convert_start_n,
    input wire logic power_down_in,
    input wire logic reset_in,
    input wire logic sample_hold,
    input wire logic [15:0] trial_code,
    input wire logic busy,
    input wire logic power_save,
    input wire logic [15:0] result_code
);
    // ========================================
    // Helper logic
    int busy_cnt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Busy length counter; scales with DIV instead of a fixed repeat
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_cnt <= 0;
        else
            busy_cnt <= busy ? busy_cnt + 1 : 0;
    end

    sequence s_begin;
        $rose(busy);
    endsequence
    sequence s_done;
        $fell(busy);
    endsequence

    // ========================================
    // Assertions
    a_start_edge: assert property (
        s_begin |-> !$past(convert_start_n))
        else $error("busy rose without a low start input");
    a_hold_msb: assert property (s_begin |=> sample_hold &&
        trial_code == 16'h8000)
        else $error("search did not open on a held input at the MSB");
    a_busy_length: assert property ($fell(busy) && !$past(reset_in)
        |-> busy_cnt == 2 + 16 * DIV)
        else $error("busy length wrong");
    a_result_settled: assert property (
        s_done |-> $stable(result_code))
        else $error("result moved as busy fell");
    a_result_busy: assert property ($changed(result_code) |-> busy)
        else $error("result changed outside a conversion");
    a_reset_abort: assert property (reset_in |=> !busy)
        else $error("abort input left busy high");
    a_pdown_refuse: assert property (
        power_down_in && !busy |=> !busy)
        else $error("start taken during power-down");
    a_save_idle: assert property (power_save |-> !busy)
        else $error("power saving during a conversion");
    a_apb_error: assert property (psel && penable && paddr > 12'h00c
        |-> pslverr && pready)
        else $error("unmapped access not flagged");
endmodule

bind scs_sequencer scs_sequencer_checker #(.DIV(DIV)) u_chk (.pclk,
    .presetn, .psel, .penable, .paddr, .pready, .pslverr, .convert_start_n,
    .power_down_in, .reset_in, .sample_hold, .trial_code, .busy, .power_save,
    .result_code);

/* File: sim/scs_analog_model.sv */
// Behavioural analog front end: tracks, holds and compares
`timescale 1ns/1ps
module scs_analog_model
(
    input wire logic pclk,
    input wire logic [15:0] level,
    input wire logic sample_hold,
    input wire logic [15:0] trial_code,
    output logic comp_above
);
    logic [15:0] held;
    // Track while acquiring, freeze once the sequencer holds
    always_ff @(posedge pclk)
    begin
        if (!sample_hold)
            held <= level;
    end
    // Comparator decision on the held sample only
    assign comp_above = held >= trial_code;
endmodule

/* File: sim/scs_sequencer_tb.sv */
// Self-checking testbench for the conversion sequencer
`timescale 1ns/1ps
module scs_sequencer_tb;
    import scs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, comp_above, sample_hold, busy, power_save;
    logic convert_start_n = 1, coding_select = 1, power_down_in = 0;
    logic reset_in = 0, input_ground_sense = 0, input_above_span = 0;
    logic result_stale;
    logic [15:0] level = 0, trial_code, result_code, last, v;
    logic [15:0] tbl [7] = '{16'hffff, 16'hfffe, 16'h8001, 16'h8000,
        16'h7fff, 16'h0001, 16'h0000};
    int errors = 0, n_checks = 0, cycles = 0, seed = 25019, i, m;

    always #20 pclk = ~pclk;

    // Short gap limit keeps the stale window reachable in simulation
    scs_sequencer #(.GAP_LIMIT(50)) uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .convert_start_n, .coding_select, .power_down_in, .reset_in,
        .comp_above, .input_ground_sense, .input_above_span, .sample_hold,
        .trial_code, .busy, .power_save, .result_code, .result_stale);
    scs_analog_model u_model (.pclk, .level, .sample_hold, .trial_code,
        .comp_above);

    // ========================================
    // Tasks and functions
    task finish_test;
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Over-range wins, then coding flips the MSB for twos complement
    function automatic logic [15:0] expc(input logic [15:0] a,
        input logic cs, input logic ov, input logic un);
        logic [15:0] c;
        c = ov ? 16'hffff : (un ? 16'h0000 : a);
        return cs ? c : c ^ 16'h8000;
    endfunction

    // One APB transfer; request held until pready is seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task wait_idle;
        @(posedge pclk);
        while (busy !== 1'b0)
            @(posedge pclk);
    endtask

    // Conversion with a second start pulse: mid-search, or after a low-power acquisition the one that starts it
    task conv(input logic cs, input logic ov, input logic un,
        input logic st);
        level <= v;
        coding_select <= cs;
        input_above_span <= ov;
        input_ground_sense <= un;
        @(posedge pclk);
        convert_start_n <= 0;
        repeat (3) @(posedge pclk);
        convert_start_n <= 1;
        repeat (4) @(posedge pclk);
        convert_start_n <= 0;
        @(posedge pclk);
        convert_start_n <= 1;
        wait_idle;
        last = expc(v, cs, ov, un);
        chk(32'(result_code), 32'(last));
        chk(32'(result_stale), 32'(st));
    endtask

    // Hang guard: roughly ten times the expected run
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            $display("Error %0t: timeout", $time);
            finish_test;
        end
    end

    // ========================================
    // Main sequence
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_CONTROL, 0);
        chk(rd, 0);
        apb(0, 12'h010, 0);
        chk({31'h0, er}, 1);
        // Every mode plus the refused one, corners and random levels
        for (m = 0; m < 4; m++)
        begin
            apb(1, OFS_CONTROL, m);
            apb(0, OFS_CONTROL, 0);
            chk(rd, (m == 3) ? 2 : m);
            // Fast mode opens after a long pause, so its first result is stale
            if (m == 1)
                repeat (60) @(posedge pclk);
            for (i = 0; i < 11; i++)
            begin
                v = (i < 7) ? tbl[i] : 16'($random(seed));
                conv(i[0], i == 8, i >= 9,
                    m == 1 && i == 0);
            end
        end
        apb(0, OFS_RESULT, 0);
        chk(rd, {16'h0, last});
        // Every one of the 44 searches ran to its latch cycle
        apb(0, OFS_COUNT, 0);
        chk(rd, 44);
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk(32'(power_save), 1);
        // Start held low through acquisition restarts the search
        @(posedge pclk);
        convert_start_n <= 0;
        repeat (3) @(posedge pclk);
        wait_idle;
        repeat (10) @(posedge pclk);
        @(negedge pclk);
        chk(32'(busy), 1);
        @(posedge pclk);
        convert_start_n <= 1;
        wait_idle;
        last = result_code;
        // Abort in mid-search keeps the previous result
        convert_start_n <= 0;
        repeat (10) @(posedge pclk);
        reset_in <= 1;
        @(posedge pclk);
        reset_in <= 0;
        convert_start_n <= 1;
        @(negedge pclk);
        chk(32'(busy), 0);
        chk(32'(result_code), 32'(last));
        // Power-down refuses a fresh start
        @(posedge pclk);
        power_down_in <= 1;
        @(posedge pclk);
        convert_start_n <= 0;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk(32'(busy), 0);
        // Status shows saving and power-down, no busy, no stale flag
        apb(0, OFS_STATUS, 0);
        chk(rd, 32'h0000_000c);
        @(posedge pclk);
        convert_start_n <= 1;
        power_down_in <= 0;
        finish_test;
    end
endmodule
